// ===== pssu_pkg.sv
// Constants, offsets and field layout of the PHY status summary block
package pssu_pkg;

   localparam int ADDR_W  = 5;
   localparam int DATA_W  = 16;
   localparam int CNT_W   = 8;
   localparam int EVT_N   = 6;

   // Management register addresses
   localparam logic [4:0] ADDR_AUTONEG_EXPANSION_REGISTER      = 5'h06;
   localparam logic [4:0] ADDR_SUMMARY   = 5'h10;
   localparam logic [4:0] ADDR_INT_SRC   = 5'h12;
   localparam logic [4:0] ADDR_FCS_CNT   = 5'h14;
   localparam logic [4:0] ADDR_RXERR_CNT = 5'h15;
   localparam logic [4:0] ADDR_SD_CTRL   = 5'h16;
   localparam logic [4:0] ADDR_PHYCTRL   = 5'h19;
   localparam logic [4:0] ADDR_TEN_STAT  = 5'h1a;
   localparam logic [4:0] ADDR_EVT_STAT  = 5'h1c;
   localparam logic [4:0] ADDR_EVT_CLR   = 5'h1d;
   localparam logic [4:0] ADDR_EVT_EN    = 5'h1e;

   // Field positions
   localparam int SD_QUAL_BIT    = 8;
   localparam int AUTONEG_EXPANSION_REGISTER_PAGE_BIT  = 1;
   localparam int TEN_POL_BIT    = 4;
   localparam int XOVER_AUTO_BIT = 15;
   localparam int XOVER_FORCE_BIT = 14;
   localparam int INT_PEND_BIT   = 15;

   // Latch slots
   localparam int LAT_RXERR = 0;
   localparam int LAT_POL   = 1;
   localparam int LAT_FCS   = 2;
   localparam int LAT_SD    = 3;
   localparam int LAT_LOCK  = 4;
   localparam int LAT_PAGE  = 5;
   localparam logic [5:0] LAT_LOW_MASK = 6'h18;

   // Values after reset, and the counter saturation limit
   localparam logic             SD_QUAL_RST    = 1'b1;
   localparam logic             XOVER_AUTO_RST = 1'b1;
   localparam logic             XOVER_FORCE_RST = 1'b0;
   localparam logic [EVT_N-1:0] EVT_EN_RST     = 6'h00;
   localparam logic [15:0]      RDATA_RST      = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST        = 8'h00;
   localparam logic [CNT_W-1:0] CNT_MAX        = 8'hff;

   typedef struct packed {
      logic       reserved;
      logic       crossover_state;
      logic       rx_err_latch;
      logic       polarity;
      logic       false_carrier_latch;
      logic       signal_detect;
      logic       descrambler_lock;
      logic       page_received;
      logic       int_pending;
      logic [6:0] lower;
   } pssu_summary_t;

endpackage

// ===== pssu_latch_bit.sv
// One latch-high or latch-low status bit with a clearing read
`timescale 1ns/10ps
module pssu_latch_bit #(
   parameter bit LATCH_LOW = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic cond,
   input  wire logic clear,
   output logic      q
);

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= 1'b0;
      end else if (LATCH_LOW) begin
         // Drop sticks until read, then follows the source
         q <= clear ? cond : (q & cond);
      end else begin
         // Event wins over a clearing read in the same cycle
         q <= cond | (q & ~clear);
      end
   end

endmodule

// ===== pssu_status_summary.sv
// PHY status summary register, upper bits, with its clearing sources
// What this block does
// - Bit 15 of the summary register ignores writes and always reads zero.
// - Bit 14 reports the crossover state, one when pairs are swapped and zero when normal.
// - The crossover bit follows auto-enable and force, tracking each swap when only auto is on.
// - Bit 13 latches on any receive error and clears only on a read of the count at 15h.
// - Bit 12 mirrors the ten megabit polarity bit and clears only on a read of that register.
// - Bit 11 latches on a false carrier and clears only on a read of the count at 14h.
// - Bit 10 is latched-low signal detect, qualified by lock when bit 8 of 16h is set.
// - Bit 9 is the latched-low descrambler lock indication.
// - Bit 8 mirrors page received of register 06h and clears only on a read of 06h.
// - Bit 7 sets on each new enabled event and clears on a read of 12h.
// - The summary register sits at management address 10h.
`timescale 1ns/10ps
module pssu_status_summary
   import pssu_pkg::*;
(
   input  wire logic              CLK_SYS,
   input  wire logic              RST,
   input  wire logic [ADDR_W-1:0] REG_ADDR,
   input  wire logic [DATA_W-1:0] REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output logic      [DATA_W-1:0] REG_RDATA,
   input  wire logic              RX_ERROR_EVT,
   input  wire logic              FALSE_CARRIER_EVT,
   input  wire logic              POLARITY_INVERTED,
   input  wire logic              RAW_SIGNAL_DETECT,
   input  wire logic              DESCRAMBLER_LOCK,
   input  wire logic              PAGE_RECEIVED_EVT,
   input  wire logic              XOVER_SWAPPED,
   output logic                   CROSSOVER_STATE,
   output logic                   IRQ
);

   function automatic logic hit(input logic              strobe,
                                input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] target);
      hit = strobe && (addr == target);
   endfunction

   // Address decode
   logic rd_summary;
   logic rd_autoneg_expansion_register;
   logic rd_int;
   logic rd_fcs;
   logic rd_rxerr;
   logic rd_ten;
   logic wr_sd_ctrl;
   logic wr_phyctrl;
   logic wr_evt_clr;
   logic wr_evt_en;

   assign rd_summary = hit(REG_RD, REG_ADDR, ADDR_SUMMARY);
   assign rd_autoneg_expansion_register    = hit(REG_RD, REG_ADDR, ADDR_AUTONEG_EXPANSION_REGISTER);
   assign rd_int     = hit(REG_RD, REG_ADDR, ADDR_INT_SRC);
   assign rd_fcs     = hit(REG_RD, REG_ADDR, ADDR_FCS_CNT);
   assign rd_rxerr   = hit(REG_RD, REG_ADDR, ADDR_RXERR_CNT);
   assign rd_ten     = hit(REG_RD, REG_ADDR, ADDR_TEN_STAT);
   assign wr_sd_ctrl = hit(REG_WR, REG_ADDR, ADDR_SD_CTRL);
   assign wr_phyctrl = hit(REG_WR, REG_ADDR, ADDR_PHYCTRL);
   assign wr_evt_clr = hit(REG_WR, REG_ADDR, ADDR_EVT_CLR);
   assign wr_evt_en  = hit(REG_WR, REG_ADDR, ADDR_EVT_EN);

   // Control registers
   logic             sd_qualify_r;
   logic             xover_auto_r;
   logic             xover_force_r;
   logic [EVT_N-1:0] evt_en_r;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sd_qualify_r <= SD_QUAL_RST;
      end else if (wr_sd_ctrl) begin
         sd_qualify_r <= REG_WDATA[SD_QUAL_BIT];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         xover_auto_r  <= XOVER_AUTO_RST;
         xover_force_r <= XOVER_FORCE_RST;
      end else if (wr_phyctrl) begin
         xover_auto_r  <= REG_WDATA[XOVER_AUTO_BIT];
         xover_force_r <= REG_WDATA[XOVER_FORCE_BIT];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         evt_en_r <= EVT_EN_RST;
      end else if (wr_evt_en) begin
         evt_en_r <= REG_WDATA[EVT_N-1:0];
      end
   end

   // Crossover state
   logic crossover_r;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         crossover_r <= 1'b0;
      end else if (xover_force_r) begin
         crossover_r <= 1'b1;
      end else if (xover_auto_r) begin
         crossover_r <= XOVER_SWAPPED;
      end else begin
         crossover_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         CROSSOVER_STATE <= 1'b0;
      end else begin
         CROSSOVER_STATE <= crossover_r;
      end
   end

   // Qualified signal detect
   logic sd_qual;

   assign sd_qual = sd_qualify_r ? (RAW_SIGNAL_DETECT & DESCRAMBLER_LOCK)
                                 : RAW_SIGNAL_DETECT;

   // Latched status bits
   logic [EVT_N-1:0] lat_cond;
   logic [EVT_N-1:0] lat_clear;
   logic [EVT_N-1:0] lat_q;

   always_comb begin
      lat_cond            = '0;
      lat_clear           = '0;
      lat_cond[LAT_RXERR] = RX_ERROR_EVT;
      lat_clear[LAT_RXERR] = rd_rxerr;
      lat_cond[LAT_POL]   = POLARITY_INVERTED;
      lat_clear[LAT_POL]  = rd_ten;
      lat_cond[LAT_FCS]   = FALSE_CARRIER_EVT;
      lat_clear[LAT_FCS]  = rd_fcs;
      lat_cond[LAT_SD]    = sd_qual;
      lat_clear[LAT_SD]   = rd_summary;
      lat_cond[LAT_LOCK]  = DESCRAMBLER_LOCK;
      lat_clear[LAT_LOCK] = rd_summary;
      lat_cond[LAT_PAGE]  = PAGE_RECEIVED_EVT;
      lat_clear[LAT_PAGE] = rd_autoneg_expansion_register;
   end

   genvar gi;
   generate
      for (gi = 0; gi < EVT_N; gi = gi + 1) begin : g_lat
         pssu_latch_bit #(
            .LATCH_LOW (LAT_LOW_MASK[gi])
         ) u_lat (
            .clk   (CLK_SYS),
            .rst   (RST),
            .cond  (lat_cond[gi]),
            .clear (lat_clear[gi]),
            .q     (lat_q[gi])
         );
      end
   endgenerate

   // Error counters, cleared by their reads
   logic [CNT_W-1:0] rxerr_cnt_r;
   logic [CNT_W-1:0] fcs_cnt_r;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rxerr_cnt_r <= CNT_RST;
      end else if (rd_rxerr) begin
         rxerr_cnt_r <= RX_ERROR_EVT ? CNT_RST + 8'h01 : CNT_RST;
      end else if (RX_ERROR_EVT && rxerr_cnt_r != CNT_MAX) begin
         rxerr_cnt_r <= rxerr_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         fcs_cnt_r <= CNT_RST;
      end else if (rd_fcs) begin
         fcs_cnt_r <= FALSE_CARRIER_EVT ? CNT_RST + 8'h01 : CNT_RST;
      end else if (FALSE_CARRIER_EVT && fcs_cnt_r != CNT_MAX) begin
         fcs_cnt_r <= fcs_cnt_r + 8'h01;
      end
   end

   // Edge history for interrupt events
   logic sd_prev_r;
   logic lock_prev_r;
   logic pol_prev_r;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sd_prev_r   <= 1'b0;
         lock_prev_r <= 1'b0;
         pol_prev_r  <= 1'b0;
      end else begin
         sd_prev_r   <= sd_qual;
         lock_prev_r <= DESCRAMBLER_LOCK;
         pol_prev_r  <= POLARITY_INVERTED;
      end
   end

   logic [EVT_N-1:0] evt_raw;

   always_comb begin
      evt_raw            = '0;
      evt_raw[LAT_RXERR] = RX_ERROR_EVT;
      evt_raw[LAT_POL]   = POLARITY_INVERTED & ~pol_prev_r;
      evt_raw[LAT_FCS]   = FALSE_CARRIER_EVT;
      evt_raw[LAT_SD]    = sd_prev_r & ~sd_qual;
      evt_raw[LAT_LOCK]  = lock_prev_r & ~DESCRAMBLER_LOCK;
      evt_raw[LAT_PAGE]  = PAGE_RECEIVED_EVT;
   end

   // Sticky event status, write one to clear, set wins
   logic [EVT_N-1:0] evt_stat_r;
   logic [EVT_N-1:0] evt_clr;

   assign evt_clr = wr_evt_clr ? REG_WDATA[EVT_N-1:0] : '0;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         evt_stat_r <= '0;
      end else begin
         evt_stat_r <= (evt_stat_r & ~evt_clr) | evt_raw;
      end
   end

   // Pending interrupt bit, cleared by reading the source register; IRQ tracks enabled sticky status
   logic int_pend_r;
   logic int_new;

   assign int_new = |(evt_raw & evt_en_r);

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         int_pend_r <= 1'b0;
      end else begin
         int_pend_r <= int_new | (int_pend_r & ~rd_int);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(evt_stat_r & evt_en_r);
      end
   end

   // Summary image
   pssu_summary_t summary;

   always_comb begin
      summary                     = '0;
      summary.reserved            = 1'b0;
      summary.crossover_state     = crossover_r;
      summary.rx_err_latch        = lat_q[LAT_RXERR];
      summary.polarity            = lat_q[LAT_POL];
      summary.false_carrier_latch = lat_q[LAT_FCS];
      summary.signal_detect       = lat_q[LAT_SD];
      summary.descrambler_lock    = lat_q[LAT_LOCK];
      summary.page_received       = lat_q[LAT_PAGE];
      summary.int_pending         = int_pend_r;
      summary.lower               = '0;
   end

   // Read data mux, zero for unmapped addresses
   logic [DATA_W-1:0] rdata_nxt;

   always_comb begin
      rdata_nxt = '0;
      if (REG_RD) begin
         case (REG_ADDR)
            ADDR_SUMMARY: begin
               rdata_nxt = summary;
            end
            ADDR_AUTONEG_EXPANSION_REGISTER: begin
               rdata_nxt[AUTONEG_EXPANSION_REGISTER_PAGE_BIT] = lat_q[LAT_PAGE];
            end
            ADDR_INT_SRC: begin
               rdata_nxt[INT_PEND_BIT] = int_pend_r;
               rdata_nxt[EVT_N-1:0]    = evt_stat_r;
            end
            ADDR_FCS_CNT: begin
               rdata_nxt[CNT_W-1:0] = fcs_cnt_r;
            end
            ADDR_RXERR_CNT: begin
               rdata_nxt[CNT_W-1:0] = rxerr_cnt_r;
            end
            ADDR_SD_CTRL: begin
               rdata_nxt[SD_QUAL_BIT] = sd_qualify_r;
            end
            ADDR_PHYCTRL: begin
               rdata_nxt[XOVER_AUTO_BIT]  = xover_auto_r;
               rdata_nxt[XOVER_FORCE_BIT] = xover_force_r;
            end
            ADDR_TEN_STAT: begin
               rdata_nxt[TEN_POL_BIT] = lat_q[LAT_POL];
            end
            ADDR_EVT_STAT: begin
               rdata_nxt[EVT_N-1:0] = evt_stat_r;
            end
            ADDR_EVT_EN: begin
               rdata_nxt[EVT_N-1:0] = evt_en_r;
            end
            default: begin
               rdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         REG_RDATA <= RDATA_RST;
      end else begin
         REG_RDATA <= rdata_nxt;
      end
   end

endmodule

// ===== pssu_summary_assertions.sv
// Port-level checks of the status summary register
`timescale 1ns/10ps
module pssu_summary_chk
   import pssu_pkg::*;
(
   input wire logic              CLK_SYS,
   input wire logic              RST,
   input wire logic [ADDR_W-1:0] REG_ADDR,
   input wire logic              REG_RD,
   input wire logic [DATA_W-1:0] REG_RDATA,
   input wire logic              RX_ERROR_EVT,
   input wire logic              FALSE_CARRIER_EVT,
   input wire logic              POLARITY_INVERTED,
   input wire logic              RAW_SIGNAL_DETECT,
   input wire logic              DESCRAMBLER_LOCK,
   input wire logic              PAGE_RECEIVED_EVT,
   input wire logic              CROSSOVER_STATE
);
   logic rd_sum;
   assign rd_sum = REG_RD && (REG_ADDR == ADDR_SUMMARY);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   a_rdata_idle_zero: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
      else $error("read data not zero outside read slot");
   a_top_bit_zero: assert property (rd_sum |=> !REG_RDATA[15])
      else $error("summary bit 15 not zero");
   a_xover_read: assert property (rd_sum |=> REG_RDATA[14] == CROSSOVER_STATE)
      else $error("summary bit 14 differs from crossover state");
   a_rxerr_set: assert property (RX_ERROR_EVT ##1 rd_sum |=> REG_RDATA[13])
      else $error("receive error latch not set");
   a_rxerr_clear: assert property (REG_RD && REG_ADDR == ADDR_RXERR_CNT && !RX_ERROR_EVT
      ##1 rd_sum |=> !REG_RDATA[13])
      else $error("receive error latch not cleared by count read");
   a_pol_mirror: assert property (POLARITY_INVERTED ##1 rd_sum |=> REG_RDATA[12])
      else $error("polarity bit not set");
   a_fcs_set: assert property (FALSE_CARRIER_EVT ##1 rd_sum |=> REG_RDATA[11])
      else $error("false carrier latch not set");
   a_sd_latch_low: assert property (!RAW_SIGNAL_DETECT ##1 rd_sum |=> !REG_RDATA[10])
      else $error("signal detect bit not latched low");
   a_lock_latch_low: assert property (!DESCRAMBLER_LOCK ##1 rd_sum |=> !REG_RDATA[9])
      else $error("lock bit not latched low");
   a_page_set: assert property (PAGE_RECEIVED_EVT ##1 rd_sum |=> REG_RDATA[8])
      else $error("page received bit not set");
endmodule

bind pssu_status_summary pssu_summary_chk pssu_summary_chk_i (.CLK_SYS, .RST, .REG_ADDR,
   .REG_RD, .REG_RDATA, .RX_ERROR_EVT, .FALSE_CARRIER_EVT, .POLARITY_INVERTED,
   .RAW_SIGNAL_DETECT, .DESCRAMBLER_LOCK, .PAGE_RECEIVED_EVT, .CROSSOVER_STATE);

// ===== test_pssu_status_summary.sv
// Self-checking testbench of the status summary register
`timescale 1ns/10ps
module test_pssu_status_summary
   import pssu_pkg::*;
;
   logic              clk_sys = 1'b0;
   logic              rst     = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [2:0]        ev = '0;
   logic              pol = 1'b0;
   logic              sd = 1'b1;
   logic              lock = 1'b1;
   logic              xsw = 1'b0;
   logic              xover;
   logic              irq;
   int                errors = 0;
   int                cmp_count = 0;
   int                cyc = 0;

   pssu_status_summary pssu_status_summary_i (.CLK_SYS(clk_sys), .RST(rst),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .RX_ERROR_EVT(ev[0]), .FALSE_CARRIER_EVT(ev[1]),
      .POLARITY_INVERTED(pol), .RAW_SIGNAL_DETECT(sd), .DESCRAMBLER_LOCK(lock),
      .PAGE_RECEIVED_EVT(ev[2]), .XOVER_SWAPPED(xsw), .CROSSOVER_STATE(xover), .IRQ(irq));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   task report_and_stop;
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         report_and_stop;
      end
   end

   task chk(string n, logic [15:0] s, logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task wr(logic [4:0] a, logic [15:0] d);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task rc(logic [4:0] a, logic [15:0] e);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      chk("rdata", reg_rdata, e);
   endtask

   task pu(logic [2:0] m);
      ev <= m;
      @(posedge clk_sys);
      ev <= '0;
   endtask

   task wt(logic [15:0] e, logic s);
      repeat (3) @(posedge clk_sys);
      chk(s ? "irq" : "xover", s ? irq : xover, e);
   endtask

   task t_reset_map;
      rc(ADDR_SUMMARY, 16'h0000);
      wr(ADDR_SUMMARY, 16'hffff);
      rc(ADDR_SUMMARY, 16'h0600);
      rc(ADDR_SD_CTRL, 16'h0100);
      rc(ADDR_PHYCTRL, 16'h8000);
      rc(5'h03, 16'h0000);
   endtask

   task t_counters;
      pu(3'b011);
      rc(ADDR_SUMMARY, 16'h2e00);
      rc(ADDR_SUMMARY, 16'h2e00);
      reg_rd <= 1'b1; reg_addr <= ADDR_RXERR_CNT;
      @(posedge clk_sys);
      reg_addr <= ADDR_SUMMARY;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      chk("rxerr count", reg_rdata, 16'h0001);
      @(posedge clk_sys);
      chk("summary", reg_rdata, 16'h0e00);
      ev[1] <= 1'b1; reg_rd <= 1'b1; reg_addr <= ADDR_FCS_CNT;
      @(posedge clk_sys);
      ev <= '0; reg_rd <= 1'b0;
      @(posedge clk_sys);
      chk("fcs count", reg_rdata, 16'h0001);
      rc(ADDR_SUMMARY, 16'h0e00);
      rc(ADDR_FCS_CNT, 16'h0001);
      rc(ADDR_SUMMARY, 16'h0600);
   endtask

   task t_polarity;
      pol <= 1'b1;
      @(posedge clk_sys);
      pol <= 1'b0;
      rc(ADDR_SUMMARY, 16'h1600);
      rc(ADDR_SUMMARY, 16'h1600);
      rc(ADDR_TEN_STAT, 16'h0010);
      rc(ADDR_SUMMARY, 16'h0600);
   endtask

   task t_detect;
      lock <= 1'b0;
      @(posedge clk_sys);
      lock <= 1'b1;
      rc(ADDR_SUMMARY, 16'h0000);
      rc(ADDR_SUMMARY, 16'h0600);
      wr(ADDR_SD_CTRL, 16'h0000);
      lock <= 1'b0;
      @(posedge clk_sys);
      lock <= 1'b1;
      rc(ADDR_SUMMARY, 16'h0400);
      sd <= 1'b0;
      @(posedge clk_sys);
      sd <= 1'b1;
      rc(ADDR_SUMMARY, 16'h0200);
      wr(ADDR_SD_CTRL, 16'h0100);
   endtask

   task t_page;
      pu(3'b100);
      rc(ADDR_SUMMARY, 16'h0700);
      rc(ADDR_SUMMARY, 16'h0700);
      rc(ADDR_AUTONEG_EXPANSION_REGISTER, 16'h0002);
      rc(ADDR_SUMMARY, 16'h0600);
   endtask

   task t_crossover;
      xsw <= 1'b1;
      wt(16'h0001, 1'b0);
      rc(ADDR_SUMMARY, 16'h4600);
      wr(ADDR_PHYCTRL, 16'h0000);
      wt(16'h0000, 1'b0);
      wr(ADDR_PHYCTRL, 16'h4000);
      xsw <= 1'b0;
      wt(16'h0001, 1'b0);
      wr(ADDR_PHYCTRL, 16'h8000);
      wt(16'h0000, 1'b0);
   endtask

   task t_interrupt;
      wr(ADDR_EVT_CLR, 16'h003f);
      rc(ADDR_EVT_STAT, 16'h0000);
      pu(3'b010);
      wt(16'h0000, 1'b1);
      rc(ADDR_SUMMARY, 16'h0e00);
      wr(ADDR_EVT_EN, 16'h0001);
      rc(ADDR_EVT_EN, 16'h0001);
      pu(3'b001);
      wt(16'h0001, 1'b1);
      rc(ADDR_SUMMARY, 16'h2e80);
      rc(ADDR_INT_SRC, 16'h8005);
      rc(ADDR_SUMMARY, 16'h2e00);
      wr(ADDR_EVT_CLR, 16'h0001);
      wt(16'h0000, 1'b1);
   endtask

   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset_map;
      t_counters;
      t_polarity;
      t_detect;
      t_page;
      t_crossover;
      t_interrupt;
      report_and_stop;
   end
endmodule
